// ==== rtl/sinc_filter_path.v ====
// Purpose: delta-sigma filter front: sinc5 decimator, fir stand-in,
//    high-pass, calibration, clipping, path select, dither and buffer mode
// Assumes: modulator word and settings come from logic on clk
// Notes: output words queue in a 16 word fifo
// Notes on behaviour
// - the first section is a fifth-order sinc decimator of ratio N.
// - modulator samples enter the sinc section at clk divided by four.
// - rate codes 000..100 give sinc ratios 256,128,64,32,16.
// - a two-bit path field picks sinc, fir, or fir plus high-pass.
// - fir and fir plus high-pass data pass calibration then clipping.
// - sinc-only data skip fir, high-pass, scaling, clip and calibration.
// - the high-pass stage removes dc and low frequencies when selected.
// - the sinc response has zeros at the output rate and its multiples.
// - dither runs at modulator rate over the combined ratio 32 times N.
// - gain code 111 selects buffer mode and powers the amplifier down.
// - the fir section decimates by a further fixed factor of 32.
`timescale 1ns/1ps
`include "sinc_filter_defines.vh"

module sinc_fifo #(
   parameter W = 25,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire reset_n,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output reg out_valid_q,
   input wire out_ready,
   output reg [W-1:0] out_data_q
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q, rd_q;
   reg [AW:0] cnt_q;
   wire push, load;

   // full at DEPTH words, output stage included; refill it when it frees
   assign in_ready = ((cnt_q + {{AW{1'b0}}, out_valid_q}) < DEPTH[AW:0]);
   assign push = in_valid & in_ready;
   assign load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

   // pointers, count and registered output word
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         out_valid_q <= 1'b0;
         out_data_q <= {W{1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (load) begin
            rd_q <= rd_q + 1'b1;
            out_data_q <= mem[rd_q];
            out_valid_q <= 1'b1;
         end else if (out_ready) begin
            out_valid_q <= 1'b0;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      end
   end

   // storage array
   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
endmodule

module sinc_filter_path #(
   parameter MOD_W = 4,
   parameter OUT_W = 24,
   parameter HP_SHIFT = 8,
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4
) (
   input wire clk,
   input wire reset_n,
   input wire [MOD_W-1:0] mod_data,
   input wire [2:0] rate_select,
   input wire [1:0] path_select,
   input wire [2:0] gain_select,
   input wire [OUT_W-1:0] cal_offset,
   input wire [OUT_W-1:0] cal_gain,
   output reg mod_take_q,
   output reg dither_q,
   output reg amp_power_down_q,
   output reg buffer_enable_q,
   output reg overrun_q,
   output wire out_valid,
   input wire out_ready,
   output wire [OUT_W-1:0] out_data,
   output wire out_sinc
);
   localparam ACC_W = MOD_W + `SINC_ORDER * `LOG2_N_MAX;
   localparam FW = OUT_W + `FIR_LOG;
   localparam HW = OUT_W + HP_SHIFT + 1;
   localparam PW = 2 * OUT_W + 3;

   reg [2:0] rate_q;
   reg [1:0] path_q, div_q;
   reg [MOD_W-1:0] smp_q;
   reg [8:0] dec_q;
   reg dstb_q, sinc_stb_q, fir_stb_q, pend_v_q;
   reg [ACC_W-1:0] int_q [0:`SINC_ORDER-1], dly_q [0:`SINC_ORDER-1];
   wire [ACC_W-1:0] int_in [0:`SINC_ORDER-1], comb [0:`SINC_ORDER];
   reg [OUT_W-1:0] sinc_q, fir_q;
   reg [FW-1:0] fir_acc_q;
   reg [4:0] fir_cnt_q;
   reg [HW-1:0] dc_q;
   reg [12:0] dith_cnt_q;
   reg [OUT_W:0] pend_q;
   wire [2:0] rate_d;
   wire rate_chg, fifo_ready, new_v;
   wire [8:0] n_last;
   wire [12:0] half_last;
   wire [ACC_W-1:0] nrm;
   wire [FW-1:0] fir_sum;
   wire signed [HW-1:0] dc_int, hp_y;
   wire signed [OUT_W:0] src;
   wire signed [OUT_W+1:0] diff;
   wire signed [PW-1:0] prod, scaled;
   wire [PW-OUT_W:0] hi;
   wire [OUT_W-1:0] clipped;
   wire [OUT_W:0] new_w;

   // reserved rate codes fall back to the last defined ratio
   assign rate_d = (rate_select > `RATE_MAX) ? `RATE_MAX
      : rate_select;
   assign rate_chg = (rate_d != rate_q);
   // sinc ratio N = 256 >> code, so the last count is N-1
   assign n_last = (`SINC_N_MAX >> rate_q) - 9'h001;
   // dither half period is 16N, a full period 32N samples
   assign half_last = (`DITHER_HALF_MAX >> rate_q) - 13'h0001;

   // settings register and buffer mode control
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rate_q <= `RATE_256;
         path_q <= `PATH_SINC;
         amp_power_down_q <= 1'b0;
         buffer_enable_q <= 1'b0;
      end else begin
         rate_q <= rate_d;
         path_q <= path_select;
         amp_power_down_q <= (gain_select == `GAIN_BUFFER);
         buffer_enable_q <= (gain_select == `GAIN_BUFFER);
      end
   end

   // modulator sample strobe at clk / 4 and sample capture
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 2'h0;
         mod_take_q <= 1'b0;
         smp_q <= {MOD_W{1'b0}};
      end else begin
         div_q <= div_q + 2'h1;
         mod_take_q <= (div_q == `MOD_DIV_LAST);
         if (div_q == `MOD_DIV_LAST) begin
            smp_q <= mod_data;
         end
      end
   end

   // five integrators at the modulator rate, wrap-around arithmetic
   assign int_in[0] = {{(ACC_W-MOD_W){smp_q[MOD_W-1]}}, smp_q};
   genvar i;
   generate
      for (i = 0; i < `SINC_ORDER; i = i + 1) begin : g_stage
         if (i > 0) begin : g_link
            assign int_in[i] = int_q[i-1];
         end
         assign comb[i+1] = comb[i] - dly_q[i];
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               int_q[i] <= {ACC_W{1'b0}};
               dly_q[i] <= {ACC_W{1'b0}};
            end else begin
               if (mod_take_q) begin
                  int_q[i] <= int_q[i] + int_in[i];
               end
               if (dstb_q) begin
                  dly_q[i] <= comb[i];
               end
            end
         end
      end
   endgenerate
   assign comb[0] = int_q[`SINC_ORDER-1];

   // unity dc gain: divide by N**5, done as a left shift to full scale
   assign nrm = comb[`SINC_ORDER] << (`SINC_ORDER * rate_q);

   // decimation counter, restarted on a ratio change
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dec_q <= 9'h000;
         dstb_q <= 1'b0;
      end else begin
         dstb_q <= 1'b0;
         if (rate_chg) begin
            dec_q <= 9'h000;
         end else if (mod_take_q) begin
            if (dec_q >= n_last) begin
               dec_q <= 9'h000;
               dstb_q <= 1'b1;
            end else begin
               dec_q <= dec_q + 9'h001;
            end
         end
      end
   end

   // sinc output word
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sinc_q <= {OUT_W{1'b0}};
         sinc_stb_q <= 1'b0;
      end else begin
         sinc_stb_q <= dstb_q;
         if (dstb_q) begin
            sinc_q <= nrm[ACC_W-1 -: OUT_W];
         end
      end
   end

   // fir stand-in: average of 32 sinc words, one word out per 32
   assign fir_sum = fir_acc_q + {{`FIR_LOG{sinc_q[OUT_W-1]}}, sinc_q};
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fir_acc_q <= {FW{1'b0}};
         fir_cnt_q <= 5'h00;
         fir_q <= {OUT_W{1'b0}};
         fir_stb_q <= 1'b0;
      end else begin
         fir_stb_q <= 1'b0;
         if (rate_chg) begin
            fir_acc_q <= {FW{1'b0}};
            fir_cnt_q <= 5'h00;
         end else if (sinc_stb_q) begin
            fir_cnt_q <= fir_cnt_q + 5'h01;
            if (fir_cnt_q == `FIR_LAST) begin
               fir_acc_q <= {FW{1'b0}};
               fir_q <= fir_sum[FW-1:`FIR_LOG];
               fir_stb_q <= 1'b1;
            end else begin
               fir_acc_q <= fir_sum;
            end
         end
      end
   end

   // high-pass: subtract a running dc estimate with pole 1 - 2**-HP_SHIFT
   assign dc_int = $signed(dc_q) >>> HP_SHIFT;
   assign hp_y = {{(HP_SHIFT+1){fir_q[OUT_W-1]}}, fir_q} - dc_int;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dc_q <= {HW{1'b0}};
      end else if (fir_stb_q) begin
         dc_q <= dc_q + hp_y;
      end
   end

   // fir or fir plus high-pass, then offset, gain and clipping
   assign src = (path_q == `PATH_FIR_HP) ? hp_y[OUT_W:0]
      : {fir_q[OUT_W-1], fir_q};
   assign diff = {src[OUT_W], src} - {{2{cal_offset[OUT_W-1]}}, cal_offset};
   assign prod = diff * $signed({1'b0, cal_gain});
   assign scaled = prod >>> `GAIN_FRAC;
   assign hi = scaled[PW-1:OUT_W-1];
   assign clipped = ((&hi) | ~(|hi)) ? scaled[OUT_W-1:0]
      : (scaled[PW-1] ? {1'b1, {(OUT_W-1){1'b0}}}
      : {1'b0, {(OUT_W-1){1'b1}}});

   // path select: sinc words bypass every later stage
   assign new_v = (path_q == `PATH_SINC) ? sinc_stb_q : fir_stb_q;
   assign new_w = (path_q == `PATH_SINC) ? {1'b1, sinc_q}
      : {1'b0, clipped};

   // holding word in front of the fifo; a full fifo stalls it
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q <= {(OUT_W+1){1'b0}};
         pend_v_q <= 1'b0;
         overrun_q <= 1'b0;
      end else begin
         overrun_q <= new_v & pend_v_q & ~fifo_ready;
         if (new_v) begin
            pend_q <= new_w;
            pend_v_q <= 1'b1;
         end else if (fifo_ready) begin
            pend_v_q <= 1'b0;
         end
      end
   end

   // dither square wave, period 32N modulator samples
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dith_cnt_q <= 13'h0000;
         dither_q <= 1'b0;
      end else if (rate_chg) begin
         dith_cnt_q <= 13'h0000;
      end else if (mod_take_q) begin
         if (dith_cnt_q >= half_last) begin
            dith_cnt_q <= 13'h0000;
            dither_q <= ~dither_q;
         end else begin
            dith_cnt_q <= dith_cnt_q + 13'h0001;
         end
      end
   end

   // output queue
   sinc_fifo #(
      .W(OUT_W + 1),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(pend_v_q),
      .in_ready(fifo_ready),
      .in_data(pend_q),
      .out_valid_q(out_valid),
      .out_ready(out_ready),
      .out_data_q({out_sinc, out_data})
   );
endmodule

// ==== rtl/sinc_filter_defines.vh ====
// Purpose: shared constants of the sinc decimator filter path
// Assumes: included by the filter path design file
// Notes: definitions only
`ifndef SINC_FILTER_DEFINES_VH
`define SINC_FILTER_DEFINES_VH

// modulator sample strobe: converter clock divided by four
`define MOD_DIV_LAST 2'h3

// rate-select codes, sinc ratio 256 down to 16
`define RATE_256 3'h0
`define RATE_128 3'h1
`define RATE_64 3'h2
`define RATE_32 3'h3
`define RATE_16 3'h4
`define RATE_MAX 3'h4

// sinc order and largest ratio exponent (2**8 = 256)
`define SINC_ORDER 5
`define LOG2_N_MAX 8
`define SINC_N_MAX 9'h100

// fir section fixed decimation of 32
`define FIR_LOG 5
`define FIR_LAST 5'h1f

// dither half period in modulator samples at ratio 256
`define DITHER_HALF_MAX 13'h1000

// path-select codes
`define PATH_SINC 2'h0
`define PATH_FIR 2'h1
`define PATH_FIR_HP 2'h2

// gain code that selects buffer operation
`define GAIN_BUFFER 3'h7

// calibration gain fraction bits (1.0 = 2**23)
`define GAIN_FRAC 23

`endif

// ==== tb/sinc_path_assertions.sv ====
// Purpose: port checks for sinc_filter_path
// Assumes: bound to every instance of the top module
// Notes: dither interval is counted in taken modulator samples
`timescale 1ns/1ps
module sinc_path_checker #(
   parameter OUT_W = 24
) (
   input wire clk,
   input wire reset_n,
   input wire [2:0] rate_select,
   input wire [2:0] gain_select,
   input wire mod_take_q,
   input wire dither_q,
   input wire amp_power_down_q,
   input wire buffer_enable_q,
   input wire overrun_q,
   input wire out_valid,
   input wire out_ready,
   input wire [OUT_W-1:0] out_data,
   input wire out_sinc
);
   reg [13:0] cnt_q;
   reg ok_q;
   reg [2:0] r1_q;
   reg [2:0] r2_q;
   reg dith_prev_q;
   wire [13:0] span;
   wire dith_flip;
   // samples per dither half period, reserved codes act as the last one
   assign span = 14'h1000 >> (rate_select > 3'h4 ? 3'h4 : rate_select);
   // a dither edge shows as a change against last cycle's level
   assign dith_flip = (dither_q != dith_prev_q);
   // count takes between dither edges, distrust it just after a rate move
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 14'h0000;
         ok_q <= 1'b0;
         r1_q <= 3'h0;
         r2_q <= 3'h0;
         dith_prev_q <= 1'b0;
      end else begin
         r1_q <= rate_select;
         r2_q <= r1_q;
         dith_prev_q <= dither_q;
         if (dith_flip)
            cnt_q <= {13'h0000, mod_take_q};
         else
            cnt_q <= cnt_q + {13'h0000, mod_take_q};
         if (rate_select != r1_q || r1_q != r2_q)
            ok_q <= 1'b0;
         else if (dith_flip)
            ok_q <= 1'b1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence take_gap;
      !mod_take_q [*3] ##1 mod_take_q;
   endsequence
   a_take_every_four: assert property (
      mod_take_q |=> take_gap) else $error("sample strobe spacing");
   a_buffer_on: assert property (
      gain_select == 3'h7 |=> amp_power_down_q) else $error("amp not down");
   a_buffer_off: assert property (
      gain_select != 3'h7 |=> !amp_power_down_q) else $error("amp down");
   a_buffer_pair: assert property (
      buffer_enable_q == amp_power_down_q) else $error("buffer mismatch");
   a_dither_span: assert property (
      $changed(dither_q) && ok_q |-> cnt_q == span)
      else $error("dither half period");
   a_hold_word: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data)
      && $stable(out_sinc)) else $error("held word moved");
   a_overrun_once: assert property (
      overrun_q |=> !overrun_q) else $error("overrun too long");
   a_overrun_full: assert property (
      overrun_q |-> $past(out_valid)) else $error("overrun while empty");
endmodule

bind sinc_filter_path sinc_path_checker #(.OUT_W(OUT_W)) u_chk (
   .clk(clk),
   .reset_n(reset_n),
   .rate_select(rate_select),
   .gain_select(gain_select),
   .mod_take_q(mod_take_q),
   .dither_q(dither_q),
   .amp_power_down_q(amp_power_down_q),
   .buffer_enable_q(buffer_enable_q),
   .overrun_q(overrun_q),
   .out_valid(out_valid),
   .out_ready(out_ready),
   .out_data(out_data),
   .out_sinc(out_sinc)
);

// ==== tb/mod_source.sv ====
// Purpose: modulator stand-in feeding the sinc path
// Assumes: the word is taken once every four clocks
// Notes: half_n of zero gives dc, else a square whose halves last half_n samples
`timescale 1ns/1ps
module mod_source (
   input wire clk,
   input wire take,
   input wire [3:0] level,
   input wire [8:0] half_n,
   output logic [3:0] mod_data
);
   logic [8:0] cnt_q = 9'h000;
   logic neg_q = 1'b0;
   // step the pattern on the falling edge inside each take pulse
   always @(negedge clk) begin
      if (take && half_n != 9'h000) begin
         cnt_q <= (cnt_q + 9'h001 >= half_n) ? 9'h000 : cnt_q + 9'h001;
         if (cnt_q + 9'h001 >= half_n)
            neg_q <= !neg_q;
      end
   end
   assign mod_data = neg_q ? -level : level;
endmodule

// ==== tb/sinc_filter_path_test.sv ====
// Purpose: self-checking bench for sinc_filter_path
// Assumes: 25 MHz clock, inputs driven on falling edges
// Notes: high-pass shift shortened to 1 so dc dies out quickly
`timescale 1ns/1ps
module sinc_filter_path_test;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] mod_data;
   logic [2:0] rate_select = 3'h0;
   logic [1:0] path_select = 2'h0;
   logic [2:0] gain_select = 3'h0;
   logic [23:0] cal_offset = 24'h00_0000;
   logic [23:0] cal_gain = 24'h80_0000;
   logic mod_take_q, dither_q, amp_power_down_q, buffer_enable_q;
   logic overrun_q, out_valid, out_sinc;
   logic out_ready = 1'b1;
   logic [23:0] out_data, word, x;
   logic [3:0] level = 4'h0;
   logic [8:0] half_n = 9'h000;
   time t_prev, t_word;
   int n_errors = 0;
   int n_checks = 0;
   sinc_filter_path #(.HP_SHIFT(1)) u_dut (.clk(clk), .reset_n(reset_n),
      .mod_data(mod_data), .rate_select(rate_select),
      .path_select(path_select), .gain_select(gain_select),
      .cal_offset(cal_offset), .cal_gain(cal_gain),
      .mod_take_q(mod_take_q), .dither_q(dither_q),
      .amp_power_down_q(amp_power_down_q),
      .buffer_enable_q(buffer_enable_q), .overrun_q(overrun_q),
      .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_sinc(out_sinc));
   mod_source u_src (.clk(clk), .take(mod_take_q), .level(level),
      .half_n(half_n), .mod_data(mod_data));
   always #20 clk = ~clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // take words from the output, keeping the last one and its time
   task automatic grab(input int skip);
      int i, k;
      for (i = 0; i <= skip; i++) begin
         @(negedge clk);
         for (k = 0; out_valid !== 1'b1 && k < 20000; k++)
            @(negedge clk);
         check(out_valid, 1);
         word = out_data;
         t_prev = t_word;
         t_word = $time;
      end
   endtask
   task automatic t_buffer;
      int g;
      for (g = 0; g < 8; g++) begin
         gain_select = g[2:0];
         repeat (2) @(negedge clk);
         check(amp_power_down_q, g == 7);
         check(buffer_enable_q, g == 7);
      end
      gain_select = 3'h0;
      $display("test buffer done");
   endtask
   task automatic t_rates;
      int c, n;
      level = 4'hb;
      // a nonzero offset must not reach sinc-only words
      cal_offset = 24'h00_1000;
      for (c = 0; c < 6; c++) begin
         rate_select = c[2:0];
         n = 256 >> (c > 4 ? 4 : c);
         grab(8);
         grab(0);
         check(32'(t_word - t_prev), 160 * n);
         check(word, 24'hb0_0000);
         check(out_sinc, 1);
      end
      cal_offset = 24'h00_0000;
      $display("test rates done");
   endtask
   task automatic t_notch;
      rate_select = 3'h2;
      level = 4'h3;
      half_n = 9'h020;
      grab(8);
      check(word, 24'h00_0000);
      half_n = 9'h000;
      $display("test notch done");
   endtask
   task automatic t_fir;
      rate_select = 3'h4;
      path_select = 2'h1;
      level = 4'h2;
      grab(3);
      grab(0);
      x = word;
      check(x, 24'h20_0000);
      check(32'(t_word - t_prev), 81920);
      check(out_sinc, 0);
      cal_offset = 24'h00_1000;
      grab(1);
      check(word, x - 24'h00_1000);
      cal_gain = 24'h40_0000;
      grab(1);
      check(word, (x - 24'h00_1000) >> 1);
      cal_gain = 24'h80_0000;
      cal_offset = 24'h80_0000;
      grab(1);
      check(word, 24'h7f_ffff);
      cal_offset = 24'h00_0000;
      $display("test fir done");
   endtask
   task automatic t_hp;
      logic [23:0] w;
      path_select = 2'h2;
      level = 4'h4;
      grab(12);
      w = word[23] ? -word : word;
      check(w < 24'h00_4000, 1);
      check(out_sinc, 0);
      $display("test highpass done");
   endtask
   // stall the consumer until a word is lost, then drain the queue
   task automatic t_fifo;
      int k, m;
      path_select = 2'h0;
      level = 4'h1;
      out_ready = 1'b0;
      for (k = 0; overrun_q !== 1'b1 && k < 4000; k++)
         @(negedge clk);
      check(overrun_q, 1);
      check(out_valid, 1);
      out_ready = 1'b1;
      for (m = 0; out_valid === 1'b1 && m < 40; m++)
         @(negedge clk);
      check(m, 17); // 16 queued words plus the held one
      $display("test fifo done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      t_buffer;
      t_rates;
      t_notch;
      t_fir;
      t_hp;
      t_fifo;
      end_sim;
   end
   // watchdog well past the expected run
   initial begin
      #4000000;
      n_errors++;
      end_sim;
   end
endmodule
